//--- clkmode_ctrl.sv
// Clock-mode controller of an audio codec: mode select, PLL lock model,
// and the bit, frame and master clock outputs.
// Assumes the power-down pin is the asynchronous reset and that the clock
// pins from the host are asynchronous to the system clock.
// Operation
// - PLL power and master/slave bits pick one of five clock schemes.
// - Master/slave bit: 1 master, 0 slave, slave after reset.
// - Slave during and after reset; master only after software writes it.
// - Master, PLL off, output enabled: master clock pin carries junk.
// - Master drives bit clock and 1fs frame; slave receives them.
// - Master clock pin low when disabled and in external slave mode.
// - Reference power, master and clock present: clocks run regardless.
// - Codes 0010, 0011 take bit clock 32fs, 64fs as reference.
// - Codes 0100,0110,0111,1100,1101 take master clock; others unusable.
// - Lock within 2 ms bit-clock reference, 10 ms master-clock.
// - Master-clock reference: rate code picks the sample rate.
// - Bit-clock reference: top rate bits pick range; 11xx unusable.
// - PLL master before first lock: bit, frame low; master junk.
// - First frame after lock may be bad; normal after one period.
// - Later lock loss makes all master-mode clocks junk.
// - Master with PLL off behaves as external master, master output junk.
// - PLL slave: master output junk until lock, then divided clock.
// - Slave and unlocked: data flagged invalid; routes can mute DAC.
// - Output divider: 256fs, 128fs, 64fs, 32fs.
// - Bit clock rate bit: 0 gives 32fs, 1 gives 64fs.
// - External modes: low rate bits give master input ratio.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module clkmode_ctrl
    import clkmode_pkg::*;
#(
    parameter int LOCK_BCLK = LOCK_BCLK_CYC,
    parameter int LOCK_MCLK = LOCK_MCLK_CYC
) (
    // Clock and power-down reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Clock pins from the host.
    input wire logic master_clock_input,
    input wire logic bit_clock_i,
    input wire logic frame_clock_i,
    // Clock pins towards the host.
    output clk_pins_t clk_pins,
    // Power and routing levels.
    output ana_ctl_t ana_ctl
);

    st_t r;
    st_t n;

    // Control decode.
    logic pll_on;
    logic ms;
    logic mck_en;
    logic bck64;
    logic vref;
    logic [3:0] ref_code;
    logic [3:0] rate;
    logic [1:0] div_sel;
    logic ref_mclk;
    clk_mode_t mode;

    assign pll_on = r.ctrl[C_PLL];
    assign ms = r.ctrl[C_MS];
    assign mck_en = r.ctrl[C_MCKEN];
    assign bck64 = r.ctrl[C_BCK64];
    assign vref = r.ctrl[C_VREF];
    assign ref_code = r.clk[K_REF +: 4];
    assign rate = r.clk[K_RATE +: 4];
    assign div_sel = r.clk[K_DIV +: 2];
    assign ref_mclk = ref_code[2];

    // Scheme selection from the two power and role bits.
    always_comb begin : mode_decode
        case ({pll_on, ms})
            2'b11: mode = MODE_PLL_MASTER;
            2'b10: mode = ref_mclk ? MODE_PLL_SLAVE_MCLK
                                   : MODE_PLL_SLAVE_BCLK;
            2'b01: mode = MODE_EXT_MASTER;
            default: mode = MODE_EXT_SLAVE;
        endcase
    end

    // Edge and presence detection on the synchronised pins.
    logic mi_rise;
    logic bi_rise;
    logic mi_here;
    logic bi_here;
    logic ref_here;

    assign mi_rise = r.mi_s[1] & ~r.mi_s[2];
    assign bi_rise = r.bi_s[1] & ~r.bi_s[2];
    assign mi_here = r.mi_age < AGE_W'(ABSENT_CYC);
    assign bi_here = r.bi_age < AGE_W'(ABSENT_CYC);
    assign ref_here = ref_mclk ? mi_here : bi_here;

    // Rate and reference checks.
    logic [7:0] pll_div;
    logic [1:0] ext_ratio;
    logic ext_ok;
    logic pll_ok;
    logic cfg_ok;
    logic [LCNT_W-1:0] lock_lim;

    assign pll_div = fs_div(rate, ref_mclk);
    assign ext_ratio = rate[1:0];
    assign ext_ok = ext_ratio != 2'h0;
    assign pll_ok = ref_ok(ref_code) && pll_div != 8'h00;
    assign cfg_ok = pll_on ? pll_ok : ext_ok;
    assign lock_lim = ref_mclk ? LCNT_W'(LOCK_MCLK)
                               : LCNT_W'(LOCK_BCLK);

    // Phase ticks: the PLL model divides the system clock, the external
    // modes count rising edges of the master clock input.
    logic pll_tick;
    logic ext_tick;
    logic tick;

    assign pll_tick = r.pst == PLL_LOCKED && r.dcnt == pll_div - 8'h01;
    assign ext_tick = !pll_on && ext_ok && mi_rise &&
                      (ext_ratio != EXT_1024 || r.half);
    assign tick = pll_on ? pll_tick : ext_tick;

    // Clean clocks derived from the phase counter.
    logic bclk_ok;
    logic fclk_ok;
    logic mclk_ok;
    logic rnd;
    logic locked;

    assign bclk_ok = bck64 ? r.ph[2] : r.ph[3];
    assign fclk_ok = r.ph[PH_W-1];
    assign mclk_ok = r.ph[div_sel];
    assign rnd = r.lfsr[0];
    assign locked = r.pst == PLL_LOCKED;

    // A clock-register write that alters reference or rate restarts lock.
    logic clk_wr;
    logic restart;

    assign clk_wr = reg_wr && reg_addr == ADDR_CLK;
    assign restart = clk_wr &&
        (reg_wdata[7:0] & CLK_MASK[7:0]) != r.clk[7:0];

    // Next state of the whole controller.
    always_comb begin : next_state
        n = r;
        // Pins pass two flip-flops before any logic looks at them.
        n.mi_s = {r.mi_s[1:0], master_clock_input};
        n.bi_s = {r.bi_s[1:0], bit_clock_i};
        n.fi_s = {r.fi_s[0], frame_clock_i};
        n.lfsr = {r.lfsr[14:0],
                  r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10]};

        // Edge age counters saturate at the absence limit.
        if (mi_rise) begin
            n.mi_age = '0;
        end else if (mi_here) begin
            n.mi_age = r.mi_age + AGE_W'(1);
        end
        if (bi_rise) begin
            n.bi_age = '0;
        end else if (bi_here) begin
            n.bi_age = r.bi_age + AGE_W'(1);
        end

        // Register writes; the role bit resets to slave.
        if (reg_wr && reg_addr == ADDR_CTRL) begin
            n.ctrl = reg_wdata & CTRL_MASK;
        end
        if (clk_wr) begin
            n.clk = reg_wdata & CLK_MASK;
        end

        // Read data stands for one cycle only.
        n.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL: n.rdata = r.ctrl;
                ADDR_CLK: n.rdata = r.clk;
                ADDR_STAT: n.rdata = {7'h00, bi_here, r.fi_s[1],
                                      r.ana.data_invalid, mi_here,
                                      ~cfg_ok, mode, locked};
                default: n.rdata = 16'h0000;
            endcase
        end

        // Phase generation; the half flag halves a 1024fs input.
        if (!pll_on && ext_ratio == EXT_1024 && mi_rise) begin
            n.half = ~r.half;
        end
        if (pll_tick || !locked) begin
            n.dcnt = 8'h00;
        end else begin
            n.dcnt = r.dcnt + 8'h01;
        end
        if (tick) begin
            n.ph = r.ph + PH_W'(1);
        end

        // Lock model. A lock restarts the phase so the first frame after
        // it is already whole.
        if (!pll_on) begin
            n.pst = PLL_OFF;
            n.lcnt = '0;
        end else begin
            case (r.pst)
                PLL_OFF: begin
                    n.pst = PLL_FIRST;
                    n.lcnt = '0;
                end
                PLL_FIRST, PLL_RELOCK: begin
                    if (restart || !cfg_ok || !ref_here) begin
                        n.lcnt = '0;
                    end else if (r.lcnt >= lock_lim - LCNT_W'(1)) begin
                        n.pst = PLL_LOCKED;
                        n.ph = '0;
                        n.lcnt = '0;
                    end else begin
                        n.lcnt = r.lcnt + LCNT_W'(1);
                    end
                end
                PLL_LOCKED: begin
                    if (restart || !cfg_ok || !ref_here) begin
                        n.pst = PLL_RELOCK;
                        n.lcnt = '0;
                    end
                end
                default: begin
                    n.pst = PLL_OFF;
                    n.lcnt = '0;
                end
            endcase
        end

        // Clock pins. Slave modes never drive bit and frame clocks.
        n.pins = '0;
        case (mode)
            MODE_PLL_MASTER: begin
                n.pins.bclk_oe = 1'b1;
                n.pins.fclk_oe = 1'b1;
                if (vref) begin
                    case (r.pst)
                        PLL_RELOCK: begin
                            n.pins.bclk_o = rnd;
                            n.pins.fclk_o = ~rnd;
                        end
                        PLL_LOCKED: begin
                            n.pins.bclk_o = bclk_ok;
                            n.pins.fclk_o = fclk_ok;
                        end
                        default: begin
                            n.pins.bclk_o = 1'b0;
                            n.pins.fclk_o = 1'b0;
                        end
                    endcase
                end
                if (mck_en) begin
                    n.pins.mclk_o = locked ? mclk_ok : rnd;
                end
            end
            MODE_PLL_SLAVE_MCLK, MODE_PLL_SLAVE_BCLK: begin
                if (mck_en) begin
                    n.pins.mclk_o = locked ? mclk_ok : rnd;
                end
            end
            MODE_EXT_MASTER: begin
                n.pins.bclk_oe = 1'b1;
                n.pins.fclk_oe = 1'b1;
                if (vref && mi_here) begin
                    n.pins.bclk_o = bclk_ok;
                    n.pins.fclk_o = fclk_ok;
                end
                // Junk while a PLL master setup is half written.
                n.pins.mclk_o = mck_en & rnd;
            end
            default: begin
                n.pins.mclk_o = 1'b0;
            end
        endcase

        // Power levels pass through; converter power does not gate the
        // master-mode clocks.
        n.ana.vref_on = vref;
        n.ana.dac_on = r.ctrl[C_DAC];
        n.ana.adc_l_on = r.ctrl[C_ADL];
        n.ana.adc_r_on = r.ctrl[C_ADR];
        n.ana.route_line = r.ctrl[C_RLINE];
        n.ana.route_spk = r.ctrl[C_RSPK];
        n.ana.data_invalid = pll_on && !ms && !locked;
    end

    // State register; power-down returns everything to slave defaults.
    always_ff @(posedge sys_clk or negedge arst_n) begin : state_reg
        if (!arst_n) begin
            r <= '0;
            r.ctrl <= CTRL_RST;
            r.clk <= CLK_RST;
            r.lfsr <= LFSR_SEED;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign clk_pins = r.pins;
    assign ana_ctl = r.ana;

endmodule : clkmode_ctrl

//--- clkmode_ctrl_chk.sv
// Port-level checker for the clock-mode controller.
// Assumes only the register port changes the registers.
`timescale 1ns/100ps
module clkmode_ctrl_chk
    import clkmode_pkg::*;
#(
    parameter int LOCK_BCLK = LOCK_BCLK_CYC
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Outputs.
    input wire clk_pins_t clk_pins,
    input wire ana_ctl_t ana_ctl
);
    logic [15:0] ctrl_r;
    logic [15:0] clk_r;
    logic [LCNT_W-1:0] cnt_r;

    // Register shadows; a clock write ends the clean power-up count.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= CTRL_RST;
            clk_r <= CLK_RST;
            cnt_r <= '0;
        end else begin
            if (reg_wr && reg_addr == ADDR_CTRL)
                ctrl_r <= reg_wdata & CTRL_MASK;
            if (reg_wr && reg_addr == ADDR_CLK)
                clk_r <= reg_wdata & CLK_MASK;
            if (!ctrl_r[C_PLL]) cnt_r <= '0;
            else if (reg_wr && reg_addr == ADDR_CLK) cnt_r <= '1;
            else if (cnt_r != '1) cnt_r <= cnt_r + 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    AST_OE_FOLLOWS_MS:
    assert property ({clk_pins.bclk_oe, clk_pins.fclk_oe}
        == {2{$past(ctrl_r[C_MS])}})
        else $error("pin drive differs from master select");
    AST_MCLK_OFF_LOW:
    assert property ($past(!ctrl_r[C_MCKEN]) |-> !clk_pins.mclk_o)
        else $error("master clock out not low while disabled");
    AST_EXT_SLAVE_LOW:
    assert property ($past(ctrl_r[1:0]) == 2'b00 |-> !clk_pins.mclk_o)
        else $error("master clock out not low in external slave");
    AST_FIRST_LOW:
    assert property ($past(ctrl_r[C_PLL] && ctrl_r[C_MS])
        && cnt_r < LCNT_W'(LOCK_BCLK) |-> !clk_pins.bclk_o && !clk_pins.fclk_o)
        else $error("clocks run before first lock");
    AST_VREF_OFF_LOW:
    assert property ($past(ctrl_r[C_MS] && !ctrl_r[C_VREF])
        |-> !clk_pins.bclk_o && !clk_pins.fclk_o)
        else $error("clocks run without reference power");
    AST_ROUTES:
    assert property ({ana_ctl.route_line, ana_ctl.route_spk}
        == $past({ctrl_r[C_RLINE], ctrl_r[C_RSPK]}))
        else $error("routing levels differ from control");
    AST_POWERS:
    assert property ({ana_ctl.vref_on, ana_ctl.dac_on, ana_ctl.adc_l_on,
        ana_ctl.adc_r_on} == $past({ctrl_r[C_VREF], ctrl_r[C_DAC],
        ctrl_r[C_ADL], ctrl_r[C_ADR]}))
        else $error("power levels differ from control");
    AST_READ_CTRL:
    assert property ($past(reg_rd && reg_addr == ADDR_CTRL)
        |-> reg_rdata == $past(ctrl_r))
        else $error("control readback wrong");
    AST_READ_CLK:
    assert property ($past(reg_rd && reg_addr == ADDR_CLK)
        |-> reg_rdata == $past(clk_r))
        else $error("clock register readback wrong");
    AST_READ_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");

    COV_MASTER_BCLK: cover property (ctrl_r[C_PLL] && $rose(clk_pins.bclk_o));
    COV_MCLK_OUT: cover property ($rose(clk_pins.mclk_o));
    COV_CLK_WRITE: cover property (reg_wr && reg_addr == ADDR_CLK);
endmodule : clkmode_ctrl_chk

bind clkmode_ctrl clkmode_ctrl_chk #(
    .LOCK_BCLK(LOCK_BCLK)
) chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clk_pins(clk_pins), .ana_ctl(ana_ctl)
);

//--- clkmode_pkg.sv
// Constants, types and decode helpers for the codec clock-mode controller.
// Assumes a 100 MHz system clock and a plain one-cycle register port.
package clkmode_pkg;

    // System clock and the lock intervals in their own units.
    localparam int SYS_HZ = 100_000_000;
    localparam int SYS_MHZ = 100;
    localparam int LOCK_BCLK_US = 2000;
    localparam int LOCK_MCLK_US = 10000;
    localparam int LOCK_BCLK_CYC = LOCK_BCLK_US * SYS_MHZ;
    localparam int LOCK_MCLK_CYC = LOCK_MCLK_US * SYS_MHZ;
    // An input clock with no rising edge for this long counts as absent.
    localparam int ABSENT_US = 20;
    localparam int ABSENT_CYC = ABSENT_US * SYS_MHZ;
    localparam int AGE_W = 12;
    localparam int LCNT_W = 24;

    // Phase ticks per sample period; bit 0 of the phase runs at 256fs.
    localparam int TICKS_PER_FS = 512;
    localparam int PH_W = $clog2(TICKS_PER_FS);

    // Register addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLK = 8'h01;
    localparam logic [7:0] ADDR_STAT = 8'h02;

    // Control register fields.
    localparam int C_PLL = 0;
    localparam int C_MS = 1;
    localparam int C_MCKEN = 2;
    localparam int C_BCK64 = 3;
    localparam int C_VREF = 4;
    localparam int C_DAC = 5;
    localparam int C_ADL = 6;
    localparam int C_ADR = 7;
    localparam int C_RLINE = 8;
    localparam int C_RSPK = 9;
    localparam logic [15:0] CTRL_MASK = 16'h03FF;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // Clock register fields: reference code, rate code, output divider.
    localparam int K_REF = 0;
    localparam int K_RATE = 4;
    localparam int K_DIV = 8;
    localparam logic [15:0] CLK_MASK = 16'h03FF;
    localparam logic [15:0] CLK_RST = 16'h00F6;

    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // Reference codes.
    localparam logic [3:0] REF_B32 = 4'h2;
    localparam logic [3:0] REF_B64 = 4'h3;
    localparam logic [3:0] REF_M11 = 4'h4;
    localparam logic [3:0] REF_M12 = 4'h6;
    localparam logic [3:0] REF_M24 = 4'h7;
    localparam logic [3:0] REF_M13 = 4'hC;
    localparam logic [3:0] REF_M27 = 4'hD;

    // External-clock ratio codes (low two rate bits).
    localparam logic [1:0] EXT_1024 = 2'h1;
    localparam logic [1:0] EXT_512L = 2'h2;
    localparam logic [1:0] EXT_512H = 2'h3;

    // Phase-tick dividers, system cycles per tick at each rate.
    localparam logic [7:0] D_8K = 8'(SYS_HZ / (TICKS_PER_FS * 8000));
    localparam logic [7:0] D_11K = 8'(SYS_HZ / (TICKS_PER_FS * 11025));
    localparam logic [7:0] D_12K = 8'(SYS_HZ / (TICKS_PER_FS * 12000));
    localparam logic [7:0] D_16K = 8'(SYS_HZ / (TICKS_PER_FS * 16000));
    localparam logic [7:0] D_22K = 8'(SYS_HZ / (TICKS_PER_FS * 22050));
    localparam logic [7:0] D_24K = 8'(SYS_HZ / (TICKS_PER_FS * 24000));
    localparam logic [7:0] D_32K = 8'(SYS_HZ / (TICKS_PER_FS * 32000));
    localparam logic [7:0] D_44K = 8'(SYS_HZ / (TICKS_PER_FS * 44100));
    localparam logic [7:0] D_48K = 8'(SYS_HZ / (TICKS_PER_FS * 48000));

    typedef enum logic [2:0] {
        MODE_PLL_MASTER,
        MODE_PLL_SLAVE_MCLK,
        MODE_PLL_SLAVE_BCLK,
        MODE_EXT_SLAVE,
        MODE_EXT_MASTER
    } clk_mode_t;

    typedef enum logic [1:0] {
        PLL_OFF,
        PLL_FIRST,
        PLL_RELOCK,
        PLL_LOCKED
    } pll_state_t;

    // Clock pins towards the host processor.
    typedef struct packed {
        logic bclk_o;
        logic bclk_oe;
        logic fclk_o;
        logic fclk_oe;
        logic mclk_o;
    } clk_pins_t;

    // Power and routing levels handed to the analog side.
    typedef struct packed {
        logic vref_on;
        logic dac_on;
        logic adc_l_on;
        logic adc_r_on;
        logic route_line;
        logic route_spk;
        logic data_invalid;
    } ana_ctl_t;

    // Whole state of the controller.
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] clk;
        logic [15:0] rdata;
        pll_state_t pst;
        logic [LCNT_W-1:0] lcnt;
        logic [7:0] dcnt;
        logic [PH_W-1:0] ph;
        logic half;
        logic [15:0] lfsr;
        logic [2:0] mi_s;
        logic [2:0] bi_s;
        logic [1:0] fi_s;
        logic [AGE_W-1:0] mi_age;
        logic [AGE_W-1:0] bi_age;
        clk_pins_t pins;
        ana_ctl_t ana;
    } st_t;

    // Valid PLL reference codes.
    function automatic logic ref_ok(input logic [3:0] code);
        case (code)
            REF_B32, REF_B64, REF_M11, REF_M12,
            REF_M24, REF_M13, REF_M27: ref_ok = 1'b1;
            default: ref_ok = 1'b0;
        endcase
    endfunction : ref_ok

    // Tick divider for a rate code; zero marks an unavailable code.
    function automatic logic [7:0] fs_div(input logic [3:0] rate,
                                          input logic ref_mclk);
        fs_div = 8'h00;
        if (ref_mclk) begin
            case (rate)
                4'h0: fs_div = D_8K;
                4'h1: fs_div = D_12K;
                4'h2: fs_div = D_16K;
                4'h3: fs_div = D_24K;
                4'h5: fs_div = D_11K;
                4'h7: fs_div = D_22K;
                4'hA: fs_div = D_32K;
                4'hB: fs_div = D_48K;
                4'hF: fs_div = D_44K;
                default: fs_div = 8'h00;
            endcase
        end else begin
            // Bit-clock reference: the top of each range stands in.
            case (rate[3:2])
                2'h0: fs_div = D_12K;
                2'h1: fs_div = D_24K;
                2'h2: fs_div = D_48K;
                default: fs_div = 8'h00;
            endcase
        end
    endfunction : fs_div

endpackage : clkmode_pkg

//--- host_clk_model.sv
// Host processor model: master clock, bit and frame clocks off it.
// Assumes the bench resolves the shared pins.
`timescale 1ns/100ps
module host_clk_model #(
    parameter real MCLK_HALF_NS = 21.0
) (
    // Control from the bench.
    input wire logic mclk_run,
    // Clocks towards the codec.
    output logic mclk,
    output logic bclk,
    output logic fclk
);
    logic [8:0] div_r = 9'h000;

    // The master clock stands low whenever the host stops it.
    initial mclk = 1'b0;
    always #(MCLK_HALF_NS) mclk = mclk_run ? ~mclk : 1'b0;

    // Counting master clock edges keeps both clocks synchronous to it.
    always @(posedge mclk) begin
        div_r <= div_r + 9'h001;
    end
    assign bclk = div_r[3];
    assign fclk = div_r[8];
endmodule : host_clk_model

//--- tb_codec_clock_mode_pll_control.sv
// Self-checking bench for the clock-mode controller.
// Assumes a free-running host master clock; shared pins pull low.
`timescale 1ns/100ps
module tb_codec_clock_mode_pll_control
    import clkmode_pkg::*;
;
    localparam int LM = 100;
    typedef struct {
        logic [7:0] wa;
        logic [15:0] wd;
        logic [7:0] ra;
        logic [15:0] mask;
        logic [15:0] exp;
    } row_t;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic host_on = 1'b0;
    logic mck;
    logic hb;
    logic hf;
    clk_pins_t clk_pins;
    ana_ctl_t ana_ctl;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    row_t rows [8];

    always #5 sys_clk = ~sys_clk;

    host_clk_model host (.mclk_run(1'b1), .mclk(mck), .bclk(hb), .fclk(hf));

    // Shared pins: the driver wins, else the pull-down.
    clkmode_ctrl #(.LOCK_BCLK(50), .LOCK_MCLK(LM)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .master_clock_input(mck),
        .bit_clock_i(clk_pins.bclk_oe ? clk_pins.bclk_o : host_on & hb),
        .frame_clock_i(clk_pins.fclk_oe ? clk_pins.fclk_o : host_on & hf),
        .clk_pins(clk_pins), .ana_ctl(ana_ctl)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // A period passes within a tolerance for sync jitter.
    task automatic near(input string nm, input int per, input int exp,
                        input int tol);
        check(nm, per inside {[exp - tol:exp + tol]} ? exp : per, exp);
    endtask : near

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rd

    // Pin select: 0 bit clock, 1 frame clock, 2 master clock.
    task automatic wait_lvl(input int sel, input logic lvl, output int n);
        n = 0;
        while (clk_pins[4 - 2 * sel] !== lvl && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 20000) begin
            mismatches++;
            $display("mismatch pin %0d expected edge seen none", sel);
        end
    endtask : wait_lvl

    // Period from one rising edge to the next, in clock cycles.
    task automatic measure(input int sel, output int per);
        int a [4];
        foreach (a[i]) wait_lvl(sel, i[0], a[i]);
        per = a[2] + a[3];
    endtask : measure

    task automatic wait_lock();
        logic [15:0] s = 16'h0000;
        int t0 = cyc;
        while (s[0] !== 1'b1 && cyc - t0 < LM + 60) rd(ADDR_STAT, s);
        check("lock", s[0], 1'b1);
    endtask : wait_lock

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        logic [15:0] s;
        int per;
        rows = '{'{8'h00, 16'hFFFF, 8'h00, 16'hFFFF, 16'h03FF},
                 '{8'h01, 16'hFC3D, 8'h01, 16'hFFFF, 16'h003D},
                 '{8'h07, 16'h1234, 8'h07, 16'hFFFF, 16'h0000},
                 '{8'h01, 16'h00F6, 8'h01, 16'hFFFF, 16'h00F6},
                 '{8'h00, 16'h0013, 8'h02, 16'h000E, 16'h0000},
                 '{8'h00, 16'h0011, 8'h02, 16'h004E, 16'h0042},
                 '{8'h00, 16'h0010, 8'h02, 16'h000E, 16'h0006},
                 '{8'h00, 16'h0002, 8'h02, 16'h000E, 16'h0008}};
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(ADDR_CTRL, s);
        check("ctrl reset", s, 16'h0000);
        rd(ADDR_CLK, s);
        check("clk reset", s, 16'h00F6);
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, s);
            check("row", s & rows[i].mask, rows[i].exp);
        end
        // Every reference code, then every rate under both references.
        wr(ADDR_CTRL, 16'h0011);
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_CLK, 16'h00B0 | 16'(c));
            rd(ADDR_STAT, s);
            if (4'(c) inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hC, 4'hD})
                check("ref", s & 16'h001E, c < 4 ? 16'h0004 : 16'h0002);
            else
                check("ref refused", s[4], 1'b1);
        end
        for (int r = 0; r < 32; r++) begin
            wr(ADDR_CLK, {8'h00, 4'(r), r < 16 ? 4'h6 : 4'h2});
            rd(ADDR_STAT, s);
            check("rate refused", s[4], r < 16 ? !(4'(r) inside {4'h0, 4'h1,
                4'h2, 4'h3, 4'h5, 4'h7, 4'hA, 4'hB, 4'hF}) : r[3:2] == 2'h3);
        end
        // PLL slave: data flagged until lock, then divided clock out.
        @(posedge sys_clk) host_on <= 1'b1;
        wr(ADDR_CLK, 16'h00F6);
        wr(ADDR_CTRL, 16'h0015);
        @(negedge sys_clk);
        check("slave unlocked", ana_ctl.data_invalid, 1'b1);
        wait_lock();
        check("slave valid", ana_ctl.data_invalid, 1'b0);
        measure(2, per);
        near("slave mclk", per, 8, 1);
        // PLL master from power-up; converters stay off throughout.
        @(posedge sys_clk) host_on <= 1'b0;
        wr(ADDR_CTRL, 16'h0000);
        wr(ADDR_CTRL, 16'h0013);
        rd(ADDR_STAT, s);
        check("first unlocked", s[0], 1'b0);
        wait_lock();
        measure(1, per);
        measure(1, per);
        near("frame", per, SYS_HZ / (512 * 44100) * 512, 2);
        measure(0, per);
        near("bit", per, SYS_HZ / (512 * 44100) * 16, 1);
        wr(ADDR_CTRL, 16'h001B);
        measure(0, per);
        near("bit fast", per, SYS_HZ / (512 * 44100) * 8, 1);
        for (int d = 0; d < 4; d++) begin
            wr(ADDR_CLK, 16'h00F6 | 16'(d << 8));
            wr(ADDR_CTRL, 16'h0017);
            measure(2, per);
            near("mclk", per, 8 << d, 1);
        end
        wr(ADDR_CLK, 16'h0036);
        rd(ADDR_STAT, s);
        check("relock", s[0], 1'b0);
        wait_lock();
        measure(1, per);
        measure(1, per);
        near("frame 24k", per, SYS_HZ / (512 * 24000) * 512, 2);
        // External master: one tick per one or two master clock edges.
        wr(ADDR_CTRL, 16'h0012);
        wr(ADDR_CLK, 16'h00F6);
        measure(1, per);
        near("ext frame", per, 512 * 42 / 10, 3);
        wr(ADDR_CLK, 16'h00D6);
        measure(1, per);
        near("ext frame slow", per, 1024 * 42 / 10, 5);
        @(posedge sys_clk) arst_n <= 1'b0;
        @(negedge sys_clk);
        check("reset pins", clk_pins, 5'h00);
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(ADDR_CTRL, s);
        check("ctrl after reset", s, 16'h0000);
        check("slave after reset", clk_pins.bclk_oe, 1'b0);
        stop_test();
    end
endmodule : tb_codec_clock_mode_pll_control
